// File: verilog/csdc_pkg.sv
/*
 shared constants of the camera sdram controller: timing counts, commands,
 sdram geometry and controller states.
 assumes a 125 mhz system clock; every system-clock cycle count is derived from it here, the tCK counts are fixed.
*/
package csdc_pkg;
   localparam int CLK_PS        = 8000;
   localparam int TCK_MIN_PS    = 166450;
   localparam int CK_DIV        = (TCK_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int CK_HI         = CK_DIV / 2;
   localparam int REF_NS        = 15600;
   localparam int REF_CYC       = REF_NS * 1000 / CLK_PS;
   localparam int REF_SLACK_TCK = 16;
   localparam int REF_GUARD     = REF_CYC - REF_SLACK_TCK * CK_DIV;
   localparam int INIT_US       = 981;
   localparam int INIT_CYC      = (INIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam longint IDLE_S    = 30;
   localparam longint IDLE_CYC  = IDLE_S * 64'd1000000000000 / CLK_PS;
   localparam int TRCD          = 1;
   localparam int TRAS          = 5;
   localparam int TRC           = 7;
   localparam int TRP           = 2;
   localparam int TMRD          = 2;
   localparam int TXSR          = 7;
   localparam int CAS_LAT       = 2;
   localparam int BURST         = 4;
   localparam int INIT_REFS     = 2;
   localparam int DQ_W          = 16;
   localparam int ROW_W         = 12;
   localparam int COL_W         = 8;
   localparam int BA_W          = 2;
   localparam int WA_W          = 22;
   localparam int FIFO_DEPTH    = 32;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [11:0] MODE_REG = 12'h022;
   localparam logic [11:0] A10_ALL  = 12'h400;
   localparam logic [11:0] DET_ROW  = 12'h800;
   localparam logic [15:0] DET_PAT0 = 16'h5a5a;
   localparam logic [15:0] DET_PAT1 = 16'ha5a5;
   typedef enum logic [6:0] {
      ST_PWR  = 7'h01,
      ST_PALL = 7'h02,
      ST_AREF = 7'h04,
      ST_MRS  = 7'h08,
      ST_IDLE = 7'h10,
      ST_ROW  = 7'h20,
      ST_SREF = 7'h40
   } csdc_state_t;
endpackage : csdc_pkg

// File: verilog/csdc_ctrl.sv
/*
 camera sdram controller: write fifo plus the sdram sequencer (init, size
 detection, burst row cycles, periodic refresh, self-refresh standby).
 assumes csdc_pkg compiled first; user side on clk_sys; sd_dq_i from a pin.
*/
`timescale 1ns/100ps
module csdc_fifo #(
   parameter int W = 16,
   parameter int D = 32
) (
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic [W-1:0]      in_data,
   output logic                   out_valid,
   input  wire logic              out_ready,
   output logic [W-1:0]           out_data,
   output logic [$clog2(D):0]     level
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = cnt_q != (AW+1)'(D);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rp_q];
   assign level     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : csdc_fifo

module csdc_sdram_ctrl #(
   parameter int          INIT_CYC   = csdc_pkg::INIT_CYC,
   parameter logic [31:0] IDLE_CYC   = 32'(csdc_pkg::IDLE_CYC),
   parameter int          FIFO_DEPTH = csdc_pkg::FIFO_DEPTH
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [15:0] wr_data,
   input  wire logic        rd_req,
   input  wire logic [21:0] rd_addr,
   output logic             rd_ready,
   output logic             rd_valid,
   output logic [15:0]      rd_data,
   input  wire logic        standby_req,
   input  wire logic        user_act,
   output logic             mem_ready,
   output logic             mem_big,
   output logic             mem_standby,
   output logic             sd_clk,
   output logic             sd_cke,
   output logic             sd_cs_n,
   output logic             sd_ras_n,
   output logic             sd_cas_n,
   output logic             sd_we_n,
   output logic [1:0]       sd_ba,
   output logic [11:0]      sd_addr,
   input  wire logic [15:0] sd_dq_i,
   output logic [15:0]      sd_dq_o,
   output logic             sd_dq_oe
);
   localparam int A_HI1 = csdc_pkg::CK_HI - 1;
   csdc_pkg::csdc_state_t st_q;
   logic [4:0]  ck_cnt_q;
   logic [3:0]  cmd_q;
   logic [1:0]  ba_q;
   logic [11:0] addr_q;
   logic [7:0]  col_q;
   logic [15:0] dq_o_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;
   logic [15:0] rd_data_q;
   logic [21:0] rd_addr_q;
   logic [21:0] wr_ptr_q;
   logic [31:0] init_q;
   logic [31:0] idle_q;
   logic [11:0] ref_q;
   logic [3:0]  wait_q;
   logic [2:0]  idx_q;
   logic [1:0]  det_q;
   logic [1:0]  ref_left_q;
   logic [1:0]  rd_wait_q;
   logic [2:0]  rd_left_q;
   logic        cke_q, dq_oe_q, op_wr_q, mrs_done_q, init_done_q, big_q;
   logic        ref_due_q, rd_pend_q, rd_valid_q;
   logic        tick, rise, step, idle_step, sleep_w, idle_exp;
   logic        ref_go, rd_go, wr_go, beat_w, pop;
   logic [15:0] fifo_data, wdat_w;
   logic [$clog2(FIFO_DEPTH):0] fifo_lvl;

   function automatic logic [13:0] map_rb(input logic [21:0] a, input logic big);
      map_rb = big ? a[21:8] : {1'b0, a[19:9], 1'b0, a[8]};
   endfunction : map_rb

   csdc_fifo #(.W(csdc_pkg::DQ_W), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (),
      .out_ready (pop),
      .out_data  (fifo_data),
      .level     (fifo_lvl)
   );

   // commands launch as the memory clock falls, sampled at its next rise
   assign tick      = ck_cnt_q == 5'(csdc_pkg::CK_HI - 1);
   assign rise      = ck_cnt_q == 5'(csdc_pkg::CK_DIV - 1);
   assign step      = tick && wait_q == '0;
   assign idle_step = step && st_q == csdc_pkg::ST_IDLE;
   assign idle_exp  = idle_q == IDLE_CYC - 32'd1;
   assign sleep_w   = standby_req || idle_exp;
   assign ref_go    = idle_step && ref_due_q;
   assign rd_go     = idle_step && !ref_due_q && init_done_q && !sleep_w && rd_pend_q;
   assign wr_go     = idle_step && !ref_due_q && init_done_q && !sleep_w && !rd_pend_q
                      && fifo_lvl >= ($clog2(FIFO_DEPTH)+1)'(csdc_pkg::BURST);
   assign beat_w    = op_wr_q && idx_q >= 3'(csdc_pkg::TRCD - 1)
                      && idx_q < 3'(csdc_pkg::TRCD - 1 + csdc_pkg::BURST);
   assign wdat_w    = init_done_q ? fifo_data
                      : (det_q == 2'h1 ? csdc_pkg::DET_PAT0 : csdc_pkg::DET_PAT1);
   assign pop       = step && st_q == csdc_pkg::ST_ROW && beat_w && init_done_q;

   assign sd_clk      = ck_cnt_q < 5'(csdc_pkg::CK_HI);
   assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_q;
   assign sd_cke      = cke_q;
   assign sd_ba       = ba_q;
   assign sd_addr     = addr_q;
   assign sd_dq_o     = dq_o_q;
   assign sd_dq_oe    = dq_oe_q;
   assign rd_ready    = !rd_pend_q;
   assign rd_valid    = rd_valid_q;
   assign rd_data     = rd_data_q;
   assign mem_ready   = init_done_q;
   assign mem_big     = big_q;
   assign mem_standby = st_q == csdc_pkg::ST_SREF;

   // 21-cycle divider: 168 ns is the nearest the 8 ns grid gives
   always_ff @(posedge clk_sys) begin
      if (srst || rise) begin
         ck_cnt_q <= '0;
      end else begin
         ck_cnt_q <= ck_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         init_q <= 32'(INIT_CYC);
      end else if (init_q != '0) begin
         init_q <= init_q - 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || user_act) begin
         idle_q <= '0;
      end else if (!idle_exp) begin
         idle_q <= idle_q + 32'h1;
      end
   end

   // guard leaves room for one row cycle before the refresh goes out;
   // held until the last init refresh and during self-refresh, so that first gap counts too
   always_ff @(posedge clk_sys) begin
      if (srst || ref_go || ref_left_q != '0 || st_q == csdc_pkg::ST_PWR
          || st_q == csdc_pkg::ST_PALL || st_q == csdc_pkg::ST_SREF) begin
         ref_q     <= '0;
         ref_due_q <= 1'b0;
      end else if (ref_q == 12'(csdc_pkg::REF_GUARD - 1)) begin
         ref_due_q <= 1'b1;
      end else begin
         ref_q <= ref_q + 12'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= '0;
      end else if (rd_req && !rd_pend_q) begin
         rd_pend_q <= 1'b1;
         rd_addr_q <= {rd_addr[21:2], 2'h0};
      end else if (rd_go) begin
         rd_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_q <= '0;
      end else if (wr_go) begin
         wr_ptr_q <= (wr_ptr_q + 22'(csdc_pkg::BURST)) & (big_q ? 22'h3fffff : 22'h0fffff);
      end
   end

   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      dq_s1_q <= sd_dq_i;
      dq_s2_q <= dq_s1_q;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_wait_q  <= '0;
         rd_left_q  <= '0;
         rd_valid_q <= 1'b0;
         rd_data_q  <= '0;
         big_q      <= 1'b0;
      end else begin
         rd_valid_q <= 1'b0;
         if (step && st_q == csdc_pkg::ST_ROW && !op_wr_q
             && idx_q == 3'(csdc_pkg::TRCD - 1)) begin
            rd_wait_q <= 2'(csdc_pkg::CAS_LAT);
            rd_left_q <= 3'(csdc_pkg::BURST);
         end else if (rise && rd_left_q != '0) begin
            if (rd_wait_q != '0) begin
               rd_wait_q <= rd_wait_q - 2'h1;
            end else begin
               rd_left_q <= rd_left_q - 3'h1;
               rd_data_q <= dq_s2_q;
               rd_valid_q <= init_done_q;
               if (!init_done_q && rd_left_q == 3'(csdc_pkg::BURST)) begin
                  big_q <= dq_s2_q != csdc_pkg::DET_PAT1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q        <= csdc_pkg::ST_PWR;
         cmd_q       <= csdc_pkg::CMD_NOP;
         ba_q        <= '0;
         addr_q      <= '0;
         col_q       <= '0;
         cke_q       <= 1'b1;
         dq_o_q      <= '0;
         dq_oe_q     <= 1'b0;
         wait_q      <= '0;
         idx_q       <= '0;
         det_q       <= '0;
         ref_left_q  <= '0;
         op_wr_q     <= 1'b0;
         mrs_done_q  <= 1'b0;
         init_done_q <= 1'b0;
      end else if (tick) begin
         cmd_q   <= csdc_pkg::CMD_NOP;
         dq_oe_q <= 1'b0;
         if (wait_q != '0) begin
            wait_q <= wait_q - 4'h1;
         end else begin
            case (st_q)
               csdc_pkg::ST_PWR: if (init_q == '0) begin
                  cmd_q  <= csdc_pkg::CMD_PRE;
                  addr_q <= csdc_pkg::A10_ALL;
                  wait_q <= 4'(csdc_pkg::TRP - 1);
                  st_q   <= csdc_pkg::ST_PALL;
               end
               csdc_pkg::ST_PALL: begin
                  cmd_q      <= csdc_pkg::CMD_REF;
                  ref_left_q <= 2'(csdc_pkg::INIT_REFS - 1);
                  wait_q     <= 4'(csdc_pkg::TRC - 1);
                  st_q       <= csdc_pkg::ST_AREF;
               end
               csdc_pkg::ST_AREF: if (ref_left_q != '0) begin
                  cmd_q      <= csdc_pkg::CMD_REF;
                  ref_left_q <= ref_left_q - 2'h1;
                  wait_q     <= 4'(csdc_pkg::TRC - 1);
               end else if (!mrs_done_q) begin
                  cmd_q  <= csdc_pkg::CMD_MRS;
                  addr_q <= csdc_pkg::MODE_REG;
                  ba_q   <= '0;
                  wait_q <= 4'(csdc_pkg::TMRD - 1);
                  st_q   <= csdc_pkg::ST_MRS;
               end else begin
                  st_q <= csdc_pkg::ST_IDLE;
               end
               csdc_pkg::ST_MRS: begin
                  mrs_done_q <= 1'b1;
                  st_q       <= csdc_pkg::ST_IDLE;
               end
               csdc_pkg::ST_IDLE: if (ref_go) begin
                  cmd_q  <= csdc_pkg::CMD_REF;
                  wait_q <= 4'(csdc_pkg::TRC - 1);
                  st_q   <= csdc_pkg::ST_AREF;
               end else if (!init_done_q) begin
                  // write row 0, write the aliasing row, read row 0 back
                  if (det_q == 2'h3) begin
                     init_done_q <= 1'b1;
                  end else begin
                     cmd_q   <= csdc_pkg::CMD_ACT;
                     ba_q    <= '0;
                     addr_q  <= det_q == 2'h1 ? csdc_pkg::DET_ROW : 12'h000;
                     col_q   <= '0;
                     op_wr_q <= det_q != 2'h2;
                     idx_q   <= '0;
                     det_q   <= det_q + 2'h1;
                     st_q    <= csdc_pkg::ST_ROW;
                  end
               end else if (sleep_w) begin
                  cmd_q <= csdc_pkg::CMD_REF;
                  cke_q <= 1'b0;
                  st_q  <= csdc_pkg::ST_SREF;
               end else if (rd_go || wr_go) begin
                  cmd_q            <= csdc_pkg::CMD_ACT;
                  {addr_q, ba_q}   <= map_rb(rd_go ? rd_addr_q : wr_ptr_q, big_q);
                  col_q            <= rd_go ? rd_addr_q[7:0] : wr_ptr_q[7:0];
                  op_wr_q          <= !rd_go;
                  idx_q            <= '0;
                  st_q             <= csdc_pkg::ST_ROW;
               end
               csdc_pkg::ST_ROW: begin
                  idx_q <= idx_q + 3'h1;
                  if (idx_q == 3'(csdc_pkg::TRCD - 1)) begin
                     cmd_q  <= op_wr_q ? csdc_pkg::CMD_WR : csdc_pkg::CMD_RD;
                     addr_q <= {4'h0, col_q};
                  end
                  if (beat_w) begin
                     dq_oe_q <= 1'b1;
                     dq_o_q  <= wdat_w;
                  end
                  if (idx_q == 3'(csdc_pkg::TRAS - 1)) begin
                     cmd_q  <= csdc_pkg::CMD_PRE;
                     addr_q <= '0;
                  end
                  if (idx_q == 3'(csdc_pkg::TRC - 2)) begin
                     st_q <= csdc_pkg::ST_IDLE;
                  end
               end
               csdc_pkg::ST_SREF: if (!sleep_w) begin
                  cke_q  <= 1'b1;
                  wait_q <= 4'(csdc_pkg::TXSR - 1);
                  st_q   <= csdc_pkg::ST_AREF;
               end
               default: st_q <= csdc_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // checking helpers: tCK since activate / precharge, cycles since refresh
   logic        tick_d_q, row_open_q;
   logic [3:0]  since_act_q, since_pre_q;
   logic [11:0] ref_age_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tick_d_q    <= 1'b0;
         row_open_q  <= 1'b0;
         since_act_q <= 4'hf;
         since_pre_q <= 4'hf;
      end else begin
         tick_d_q <= tick;
         if (tick_d_q) begin
            since_act_q <= cmd_q == csdc_pkg::CMD_ACT ? 4'h1
                           : (since_act_q == 4'hf ? 4'hf : since_act_q + 4'h1);
            since_pre_q <= cmd_q == csdc_pkg::CMD_PRE ? 4'h1
                           : (since_pre_q == 4'hf ? 4'hf : since_pre_q + 4'h1);
            if (cmd_q == csdc_pkg::CMD_ACT) row_open_q <= 1'b1;
            else if (cmd_q == csdc_pkg::CMD_PRE) row_open_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst || !mrs_done_q || st_q == csdc_pkg::ST_SREF
          || (tick_d_q && cmd_q == csdc_pkg::CMD_REF)) ref_age_q <= '0;
      else if (ref_age_q != 12'hfff) ref_age_q <= ref_age_q + 12'h001;
   end

   property p_clk;
      @(posedge clk_sys) disable iff (srst)
      $rose(sd_clk) |-> ##A_HI1 sd_clk ##1 !sd_clk;
   endproperty
   a_clk: assert property (p_clk) else $error("memory clock high phase wrong");
   property p_rcd;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && (cmd_q == csdc_pkg::CMD_RD || cmd_q == csdc_pkg::CMD_WR)
      |-> since_act_q >= 4'(csdc_pkg::TRCD) && row_open_q;
   endproperty
   a_rcd: assert property (p_rcd) else $error("access too soon after activate");
   property p_ras;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && cmd_q == csdc_pkg::CMD_PRE && mrs_done_q
      |-> since_act_q == 4'(csdc_pkg::TRAS);
   endproperty
   a_ras: assert property (p_ras) else $error("row not open exactly five tCK");
   property p_rc;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && cmd_q == csdc_pkg::CMD_ACT |-> since_act_q >= 4'(csdc_pkg::TRC);
   endproperty
   a_rc: assert property (p_rc) else $error("activates too close");
   property p_rp;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && cmd_q == csdc_pkg::CMD_ACT |-> since_pre_q >= 4'(csdc_pkg::TRP);
   endproperty
   a_rp: assert property (p_rp) else $error("activate too soon after precharge");
   property p_pair;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && cmd_q == csdc_pkg::CMD_ACT |-> !row_open_q;
   endproperty
   a_pair: assert property (p_pair) else $error("activate while row open");
   property p_ref;
      @(posedge clk_sys) disable iff (srst)
      ref_age_q < 12'(csdc_pkg::REF_CYC);
   endproperty
   a_ref: assert property (p_ref) else $error("refresh interval exceeded");
   property p_sref;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && st_q == csdc_pkg::ST_SREF && $past(st_q) == csdc_pkg::ST_SREF
      |-> cmd_q == csdc_pkg::CMD_NOP && !sd_cke;
   endproperty
   a_sref: assert property (p_sref) else $error("command during self-refresh");
   property p_init;
      @(posedge clk_sys) disable iff (srst)
      cmd_q != csdc_pkg::CMD_NOP |-> init_q == '0;
   endproperty
   a_init: assert property (p_init) else $error("command during init wait");
   property p_mrs;
      @(posedge clk_sys) disable iff (srst)
      cmd_q == csdc_pkg::CMD_ACT |-> mrs_done_q;
   endproperty
   a_mrs: assert property (p_mrs) else $error("activate before mode set");
   property p_det;
      @(posedge clk_sys) disable iff (srst)
      $rose(init_done_q) |-> det_q == 2'h3 && $stable(big_q);
   endproperty
   a_det: assert property (p_det) else $error("ready before size check");
   property p_geo;
      @(posedge clk_sys) disable iff (srst)
      cmd_q == csdc_pkg::CMD_ACT && init_done_q && !big_q |-> !sd_ba[1] && !sd_addr[11];
   endproperty
   a_geo: assert property (p_geo) else $error("small part address out of range");
   property p_wbeat;
      @(posedge clk_sys) disable iff (srst)
      tick_d_q && cmd_q == csdc_pkg::CMD_WR |-> sd_dq_oe;
   endproperty
   a_wbeat: assert property (p_wbeat) else $error("write without data beat");
   property p_sleep;
      @(posedge clk_sys) disable iff (srst)
      $rose(idle_exp) && init_done_q |-> ##[0:600] (mem_standby || !sleep_w);
   endproperty
   a_sleep: assert property (p_sleep) else $error("no standby after idle time");
   c_write: cover property (@(posedge clk_sys) tick_d_q && cmd_q == csdc_pkg::CMD_WR);
   c_read: cover property (@(posedge clk_sys) rd_valid_q);
   c_sref: cover property (@(posedge clk_sys) $rose(mem_standby));
   c_small: cover property (@(posedge clk_sys) $rose(init_done_q) && !big_q);
endmodule : csdc_sdram_ctrl

// File: tb/csdc_sdram_model.sv
/*
 behavioural 16-bit sdram standing on the controller's memory pins.
 assumes commands sampled at sd_clk rise, cas latency 2, bursts of 4.
*/
`timescale 1ns/100ps
module csdc_sdram_model #(
   parameter bit BIG = 1'b1
) (
   input  wire logic        sd_clk,
   input  wire logic        sd_cs_n,
   input  wire logic        sd_ras_n,
   input  wire logic        sd_cas_n,
   input  wire logic        sd_we_n,
   input  wire logic [1:0]  sd_ba,
   input  wire logic [11:0] sd_addr,
   input  wire logic [15:0] sd_dq_o,
   input  wire logic        sd_dq_oe,
   output logic [15:0]      sd_dq_i
);
   logic [15:0] mem [int];
   logic [11:0] row_q [4];
   logic [3:0]  cmd;
   int          wk, rk, wn, rn;
   bit          big_sel = BIG;
   assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   // small part decodes neither row bit 11 nor bank bit 1
   function automatic int key(input logic [1:0] b, input logic [7:0] c);
      return big_sel ? int'({b, row_q[b], c}) : int'({b[0], row_q[b][10:0], c});
   endfunction : key
   initial sd_dq_i = 16'h0000;
   always @(posedge sd_clk) begin
      if (cmd == csdc_pkg::CMD_ACT)
         row_q[sd_ba] = sd_addr;
      if (cmd == csdc_pkg::CMD_WR) begin
         wk = key(sd_ba, sd_addr[7:0]);
         wn = 4;
      end
      if (wn > 0) begin
         // an undriven beat stores garbage so a missing enable shows up
         mem[wk + 4 - wn] = sd_dq_oe ? sd_dq_o : ~sd_dq_o;
         wn = wn - 1;
      end
      // released bus toggles so a late sample never matches by luck
      if (rn > 0) begin
         sd_dq_i <= mem.exists(rk + 4 - rn) ? mem[rk + 4 - rn] : ~sd_dq_i;
         rn = rn - 1;
      end else
         sd_dq_i <= ~sd_dq_i;
      if (cmd == csdc_pkg::CMD_RD) begin
         rk = key(sd_ba, sd_addr[7:0]);
         rn = 4;
      end
   end
endmodule : csdc_sdram_model

// File: tb/csdc_sdram_ctrl_tb.sv
/*
 bench for the camera sdram controller against a 4M x16 memory model.
 assumes csdc_pkg, the design and csdc_sdram_model compiled before.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module csdc_sdram_ctrl_tb;
   localparam int INIT_P = 50;
   localparam int IDLE_P = 2000;
   logic clk_sys = 1'b0, srst = 1'b1, wr_valid = 1'b0, rd_req = 1'b0;
   logic standby_req = 1'b0, user_act = 1'b1;
   logic [15:0] wr_data = 16'h0000, sd_dq_i, sd_dq_o, rd_data;
   logic [21:0] rd_addr = 22'h000000;
   logic wr_ready, rd_ready, rd_valid, mem_ready, mem_big, mem_standby;
   logic sd_clk, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe;
   logic [1:0]  sd_ba;
   logic [11:0] sd_addr;
   logic [3:0]  cmd;
   logic [3:0]  init_q [$];
   int bad_count = 0, n_checks = 0, tck = 0, act_t = -99, pre_t = -99;
   int wr_n = 0, ref_n = 0, cyc, n0;
   realtime ref_t = 0.0, ck_t = 0.0;
   csdc_sdram_ctrl #(.INIT_CYC(INIT_P), .IDLE_CYC(32'(IDLE_P))) dut_u (.*);
   csdc_sdram_model #(.BIG(1'b1)) mem_u (.*);
   assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   initial forever #4 clk_sys = ~clk_sys;
   always @(posedge sd_clk) begin
      tck++;
      if (ck_t > 0.0 && !srst)
         `CHK("ck period", csdc_pkg::CK_DIV * 8, int'($realtime - ck_t))
      // self-refresh or a divider reset restarts the period check
      ck_t = (sd_cke && !srst) ? $realtime : 0.0;
      if (!mem_ready && cmd < csdc_pkg::CMD_NOP)
         init_q.push_back(cmd);
      if (cmd == csdc_pkg::CMD_ACT) begin
         if (mem_ready)
            `CHK("act gaps", 2'b11, {tck - act_t >= 7, tck - pre_t >= 2})
         act_t = tck;
      end
      if (cmd == csdc_pkg::CMD_PRE) begin
         if (mem_ready)
            `CHK("row open", 5, tck - act_t)
         pre_t = tck;
      end
      if (mem_ready && (cmd == csdc_pkg::CMD_RD || cmd == csdc_pkg::CMD_WR))
         `CHK("act to cmd", 1'b1, tck - act_t >= 1)
      if (mem_ready && cmd == csdc_pkg::CMD_WR)
         wr_n++;
      if (sd_cke && cmd == csdc_pkg::CMD_REF)
         ref_n++;
      if (!sd_cke || cmd == csdc_pkg::CMD_REF)
         ref_t = $realtime;
      else if (mem_ready && $realtime - ref_t > 15600.0) begin
         `CHK("ref gap", 1'b0, 1'b1)
         ref_t = $realtime;
      end
   end
   task automatic put_n(input int first, input int n);
      @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         wr_valid <= 1'b1;
         wr_data  <= 16'(16'h1000 + first + i);
         do @(negedge clk_sys); while (!wr_ready);
         @(posedge clk_sys);
      end
      wr_valid <= 1'b0;
   endtask : put_n
   task automatic wait_wr(input int n);
      cyc = 0;
      do begin @(negedge clk_sys); cyc++; end while (wr_n < n && cyc < 5000);
   endtask : wait_wr
   task automatic get4(input int a, input int off);
      int k;
      @(posedge clk_sys);
      rd_req  <= 1'b1;
      rd_addr <= 22'(a + off);
      do @(negedge clk_sys); while (!rd_ready);
      @(posedge clk_sys);
      rd_req <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         k = 0;
         do begin @(negedge clk_sys); k++; end while (!rd_valid && k < 900);
         `CHK("rd word", 16'(16'h1000 + a + j), rd_data)
      end
   endtask : get4
   task automatic t_init;
      `CHK("oe in reset", 1'b0, sd_dq_oe)
      @(posedge clk_sys);
      srst <= 1'b0;
      cyc = 0;
      do begin @(negedge clk_sys); cyc++; end while (!mem_ready && cyc < 8000);
      `CHK("init wait", 1'b1, cyc >= INIT_P)
      `CHK("size", 1'b1, mem_big)
      `CHK("init order", 16'h2110, {init_q[0], init_q[1], init_q[2], init_q[3]})
      $display("test init done");
   endtask : t_init
   task automatic t_rw;
      put_n(0, 8);
      wait_wr(2);
      get4(0, 0);
      get4(4, 3);
      $display("test write read done");
   endtask : t_rw
   task automatic t_sleep;
      @(posedge clk_sys);
      user_act <= 1'b0;
      cyc = 0;
      do begin @(negedge clk_sys); cyc++; end while (!mem_standby && cyc < 6000);
      `CHK("idle span", 1'b1, cyc >= IDLE_P)
      `CHK("cke sleep", 1'b0, sd_cke)
      n0 = ref_n;
      put_n(8, 32);
      @(negedge clk_sys);
      `CHK("fifo full", 1'b0, wr_ready)
      // outlast one refresh interval to catch an own refresh
      repeat (2500) @(posedge clk_sys);
      `CHK("own refresh", n0, ref_n)
      user_act <= 1'b1;
      wait_wr(10);
      for (int a = 8; a < 40; a += 4)
         get4(a, 1);
      @(posedge clk_sys);
      standby_req <= 1'b1;
      cyc = 0;
      do begin @(negedge clk_sys); cyc++; end while (!mem_standby && cyc < 900);
      `CHK("req standby", 1'b1, mem_standby)
      @(posedge clk_sys);
      standby_req <= 1'b0;
      repeat (200) @(posedge clk_sys);
      `CHK("wake", 1'b0, mem_standby)
      $display("test standby done");
   endtask : t_sleep
   task automatic t_small;
      @(posedge clk_sys);
      srst          <= 1'b1;
      mem_u.big_sel <= 1'b0;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      ck_t = 0.0;
      cyc = 0;
      do begin @(negedge clk_sys); cyc++; end while (!mem_ready && cyc < 8000);
      `CHK("small ready", 1'b1, mem_ready)
      `CHK("small size", 1'b0, mem_big)
      n0 = wr_n;
      put_n(0, 4);
      wait_wr(n0 + 1);
      get4(0, 0);
      $display("test small size done");
   endtask : t_small
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      repeat (20) @(posedge clk_sys);
      t_init();
      t_rw();
      t_sleep();
      t_small();
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      final_report();
   end
endmodule : csdc_sdram_ctrl_tb
